// [src/dcc_map.svh]
// register offsets, reset values and field constants of the dma channels
// assumes byte addressing on a 32-bit wishbone bus, one register per word
//
// How it works
// [RL1] source width bit picks word or byte read
// [RL2] trigger bit picks rising edge or high level
// [RL3] triggers ignored while channel enable is clear
// [RL4] interrupt flag shows one while interrupt pending
// [RL5] interrupt request only when flag and enable set
// [RL6] nmi during transfer sets abort status bit
// [RL7] software request starts transfer, then clears itself
// [RL8] source address register never altered by transfers
// [RL9] destination address register never altered by transfers
// [RL10] extended words: bits fifteen to four read zero
// [RL11] word write to address clears its extended word
// [RL12] word reads of extended words return zero
// [RL13] size register sets units per block
// [RL14] size count drops by one per unit
// [RL15] count reaching zero reloads programmed size at once
// [RL16] size zero disables channel, else exact count
// [RL17] vector gives 2, 4, 6; channel zero first
`ifndef DCC_MAP_SVH
`define DCC_MAP_SVH

// offsets inside one channel window
`define DCC_OFF_CTL 5'h00
`define DCC_OFF_SA 5'h04
`define DCC_OFF_SAX 5'h08
`define DCC_OFF_DA 5'h0C
`define DCC_OFF_DAX 5'h10
`define DCC_OFF_SZ 5'h14
// shared vector register
`define DCC_ADR_IV 8'h60

// reset values
`define DCC_CTL_RST 8'h00
`define DCC_WORD_RST 16'h0000
`define DCC_EXT_RST 4'h0

// vector encoding
`define DCC_IV_NONE 16'h0000
`define DCC_IV_STEP 16'h0002

`endif

// [src/dcc_pkg.sv]
// types shared by the dma channel block
// assumes the offsets of dcc_map.svh
package dcc_pkg;

  typedef struct packed {
    logic dst_byte_select;
    logic source_width_select;
    logic trigger_sensitivity_select;
    logic channel_enable_bit;
    logic channel_irq_flag;
    logic channel_irq_enable;
    logic nmi_abort_status;
    logic software_start_request;
  } dcc_ctl_t;

  typedef struct packed {
    logic req;
    logic we;
    logic byte_sel;
    logic [19:0] addr;
    logic [15:0] wdata;
  } dcc_mem_req_t;

  typedef enum logic [1:0] {DCC_IDLE, DCC_RD, DCC_GAP, DCC_WR} dcc_state_t;

endpackage

// [src/dcc_trig.sv]
// trigger input conditioning for one dma channel
// assumes trig_i is asynchronous to clk_i
`timescale 1ns/1ns
`default_nettype none

module dcc_trig (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // trigger pin and mode
  input wire logic trig_i,
  input wire logic level_i,
  // conditioned request
  output logic req_o
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end
    else
    begin
      s1_q <= trig_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign req_o = level_i ? s2_q : (s2_q & ~s3_q); // [RL2]

endmodule

`default_nettype wire

// [src/dcc_top.sv]
// dma channel registers, trigger handling and single-unit mover
// assumes a classic wishbone master and a memory port that holds ack
// for one cycle per request; trigger and nmi pins are asynchronous
`timescale 1ns/1ns
`include "dcc_map.svh"
`default_nettype none

module dcc_top #(
  parameter int NCH = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // trigger and abort pins
  input wire logic [NCH-1:0] trig_i,
  input wire logic nmi_i,
  // memory master
  output dcc_pkg::dcc_mem_req_t mem_o,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i,
  // interrupt requests
  output logic [NCH-1:0] irq_o
);

  localparam int CW = (NCH > 1) ? $clog2(NCH) : 1;

  function automatic logic [15:0] dcc_merge(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] sel);
    dcc_merge = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic [CW-1:0] dcc_pick(input logic [NCH-1:0] p);
    dcc_pick = '0;
    for (int k = NCH - 1; k >= 0; k--)
    begin
      if (p[k])
      begin
        dcc_pick = CW'(k);
      end
    end
  endfunction

  // bus decode
  logic ack_q;
  logic [31:0] dat_q;
  wire logic acc = wb_cyc_i & wb_stb_i & ~ack_q;
  wire logic wr = acc & wb_we_i;
  wire logic [2:0] a_ch = wb_adr_i[7:5];
  wire logic [4:0] a_reg = wb_adr_i[4:0];
  wire logic iv_hit = (wb_adr_i == `DCC_ADR_IV);
  wire logic ch_hit = (32'(a_ch) < NCH);

  // abort pin synchroniser
  logic nmi_s1_q;
  logic nmi_s2_q;
  logic nmi_s3_q;
  wire logic nmi_rise = nmi_s2_q & ~nmi_s3_q;

  // mover state
  dcc_pkg::dcc_state_t st_q;
  logic [CW-1:0] cur_q;
  dcc_pkg::dcc_mem_req_t mem_q;
  logic [NCH-1:0] irq_q;

  // per-channel state visible to the mover
  dcc_pkg::dcc_ctl_t ctl_q [NCH];
  logic [15:0] sa_q [NCH];
  logic [3:0] sax_q [NCH];
  logic [15:0] da_q [NCH];
  logic [3:0] dax_q [NCH];
  logic [15:0] rdv [NCH];
  logic [NCH-1:0] pend_q;
  logic [NCH-1:0] ifg;

  wire logic busy = (st_q != dcc_pkg::DCC_IDLE);
  wire logic [NCH-1:0] cur_oh = NCH'(1) << cur_q;
  wire logic [NCH-1:0] srv =
    (st_q == dcc_pkg::DCC_WR && mem_ack_i && !nmi_rise) ? cur_oh : '0;
  wire logic [NCH-1:0] abt = (busy && nmi_rise) ? cur_oh : '0; // [RL6]

  genvar i;
  generate
    for (i = 0; i < NCH; i++)
    begin : g_ch
      wire logic sel_ch = ch_hit & (a_ch == 3'(i));
      wire logic wr_ctl = wr & sel_ch & (a_reg == `DCC_OFF_CTL);
      wire logic wr_sa = wr & sel_ch & (a_reg == `DCC_OFF_SA);
      wire logic wr_sax = wr & sel_ch & (a_reg == `DCC_OFF_SAX);
      wire logic wr_da = wr & sel_ch & (a_reg == `DCC_OFF_DA);
      wire logic wr_dax = wr & sel_ch & (a_reg == `DCC_OFF_DAX);
      wire logic wr_sz = wr & sel_ch & (a_reg == `DCC_OFF_SZ);
      wire logic hw_req;
      logic [15:0] sz_q;
      logic [15:0] cnt_q;
      dcc_pkg::dcc_ctl_t ctl_d;
      wire logic sz_live = (sz_q != `DCC_WORD_RST); // [RL16]
      wire logic trig_ok = ctl_q[i].channel_enable_bit & sz_live & // [RL3]
        (ctl_q[i].software_start_request | hw_req); // [RL7]
      wire logic last = (cnt_q == 16'h0001);

      dcc_trig u_trig (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .trig_i(trig_i[i]),
        .level_i(ctl_q[i].trigger_sensitivity_select),
        .req_o(hw_req)
      );

      always_comb
      begin
        ctl_d = ctl_q[i];
        ctl_d.software_start_request = 1'b0; // [RL7]
        if (wr_ctl && wb_sel_i[0])
        begin
          ctl_d = dcc_pkg::dcc_ctl_t'(wb_dat_i[7:0]);
        end
        if (srv[i] && last)
        begin
          ctl_d.channel_irq_flag = 1'b1; // [RL4]
        end
        if (abt[i])
        begin
          ctl_d.nmi_abort_status = 1'b1; // [RL6]
        end
      end

      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          ctl_q[i] <= dcc_pkg::dcc_ctl_t'(`DCC_CTL_RST);
          pend_q[i] <= 1'b0;
        end
        else
        begin
          ctl_q[i] <= ctl_d;
          pend_q[i] <= ((pend_q[i] & ~srv[i] & ~abt[i]) | trig_ok) &
            ctl_q[i].channel_enable_bit; // [RL3]
        end
      end

      // address registers change only by software writes
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          sa_q[i] <= `DCC_WORD_RST;
          sax_q[i] <= `DCC_EXT_RST;
          da_q[i] <= `DCC_WORD_RST;
          dax_q[i] <= `DCC_EXT_RST;
        end
        else
        begin
          if (wr_sa)
          begin
            sa_q[i] <= dcc_merge(sa_q[i], wb_dat_i, wb_sel_i); // [RL8]
            sax_q[i] <= `DCC_EXT_RST; // [RL11]
          end
          else if (wr_sax && wb_sel_i[0])
          begin
            sax_q[i] <= wb_dat_i[3:0]; // [RL10]
          end
          if (wr_da)
          begin
            da_q[i] <= dcc_merge(da_q[i], wb_dat_i, wb_sel_i); // [RL9]
            dax_q[i] <= `DCC_EXT_RST; // [RL11]
          end
          else if (wr_dax && wb_sel_i[0])
          begin
            dax_q[i] <= wb_dat_i[3:0]; // [RL10]
          end
        end
      end

      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          sz_q <= `DCC_WORD_RST;
          cnt_q <= `DCC_WORD_RST;
        end
        else if (wr_sz)
        begin
          sz_q <= dcc_merge(sz_q, wb_dat_i, wb_sel_i); // [RL13]
          cnt_q <= dcc_merge(sz_q, wb_dat_i, wb_sel_i);
        end
        else if (srv[i])
        begin
          cnt_q <= last ? sz_q : cnt_q - 16'h0001; // [RL14] [RL15]
        end
      end

      assign ifg[i] = ctl_q[i].channel_irq_flag;
      // extended words read as zero over word access
      assign rdv[i] =
        (a_reg == `DCC_OFF_CTL) ? {8'h00, ctl_q[i]} :
        (a_reg == `DCC_OFF_SA) ? sa_q[i] :
        (a_reg == `DCC_OFF_DA) ? da_q[i] :
        (a_reg == `DCC_OFF_SZ) ? cnt_q : `DCC_WORD_RST; // [RL12]
    end
  endgenerate

  // highest priority pending flag, channel zero first
  function automatic logic [15:0] dcc_vec(input logic [NCH-1:0] f);
    dcc_vec = `DCC_IV_NONE;
    for (int k = NCH - 1; k >= 0; k--)
    begin
      if (f[k])
      begin
        dcc_vec = 16'(k + 1) * `DCC_IV_STEP; // [RL17]
      end
    end
  endfunction

  wire logic [15:0] iv_val = dcc_vec(ifg);
  wire logic [15:0] rd_val = iv_hit ? iv_val :
    ch_hit ? rdv[a_ch[CW-1:0]] : `DCC_WORD_RST;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end
    else
    begin
      ack_q <= acc;
      dat_q <= {16'h0000, rd_val};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      nmi_s1_q <= 1'b0;
      nmi_s2_q <= 1'b0;
      nmi_s3_q <= 1'b0;
      irq_q <= '0;
    end
    else
    begin
      nmi_s1_q <= nmi_i;
      nmi_s2_q <= nmi_s1_q;
      nmi_s3_q <= nmi_s2_q;
      for (int k = 0; k < NCH; k++)
      begin
        irq_q[k] <= ctl_q[k].channel_irq_flag &
          ctl_q[k].channel_irq_enable; // [RL5]
      end
    end
  end

  // mover: read one unit, gap, write one unit
  wire logic [CW-1:0] nxt = dcc_pick(pend_q);
  wire logic src_byte = ctl_q[nxt].source_width_select;
  wire logic [15:0] rd_unit =
    ctl_q[cur_q].source_width_select ? {8'h00, mem_rdata_i[7:0]} :
    mem_rdata_i; // [RL1]

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q <= dcc_pkg::DCC_IDLE;
      cur_q <= '0;
      mem_q <= '0;
    end
    else if (busy && nmi_rise)
    begin
      st_q <= dcc_pkg::DCC_IDLE; // [RL6]
      mem_q.req <= 1'b0;
    end
    else
    begin
      unique case (st_q)
        dcc_pkg::DCC_IDLE:
        begin
          if (pend_q != '0)
          begin
            cur_q <= nxt;
            mem_q.req <= 1'b1;
            mem_q.we <= 1'b0;
            mem_q.byte_sel <= src_byte; // [RL1]
            mem_q.addr <= {sax_q[nxt], sa_q[nxt]};
            st_q <= dcc_pkg::DCC_RD;
          end
        end
        dcc_pkg::DCC_RD:
        begin
          if (mem_ack_i)
          begin
            mem_q.req <= 1'b0;
            mem_q.wdata <= rd_unit;
            st_q <= dcc_pkg::DCC_GAP;
          end
        end
        dcc_pkg::DCC_GAP:
        begin
          mem_q.req <= 1'b1;
          mem_q.we <= 1'b1;
          mem_q.byte_sel <= ctl_q[cur_q].dst_byte_select;
          mem_q.addr <= {dax_q[cur_q], da_q[cur_q]};
          st_q <= dcc_pkg::DCC_WR;
        end
        dcc_pkg::DCC_WR:
        begin
          if (mem_ack_i)
          begin
            mem_q.req <= 1'b0;
            mem_q.we <= 1'b0;
            st_q <= dcc_pkg::DCC_IDLE;
          end
        end
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign mem_o = mem_q;
  assign irq_o = irq_q;

endmodule

`default_nettype wire

// [sim/dcc_mem.sv]
// memory slave model for the dma memory port
// same clock as dcc_top; slow_i adds three wait cycles
`timescale 1ns/1ns
`default_nettype none

module dcc_mem (
  // clock and mode
  input wire logic clk_i,
  input wire logic slow_i,
  // memory port
  input wire dcc_pkg::dcc_mem_req_t mem_i,
  output logic ack_o,
  output logic [15:0] rdata_o
);
  logic [1:0] wait_q = 2'h0;
  logic fire_q = 1'b0;
  logic [15:0] junk_q = 16'h5A5A;
  // no ack once the request is withdrawn
  assign ack_o = fire_q && mem_i.req;
  assign rdata_o = ack_o ?
    mem_i.addr[15:0] ^ {mem_i.addr[19:16], 12'hA5C} : junk_q;
  always @(posedge clk_i)
  begin
    junk_q <= ~junk_q;
    fire_q <= !fire_q && wait_q == 2'h0 && mem_i.req === 1'b1;
    if (mem_i.req !== 1'b1 || fire_q)
      wait_q <= slow_i ? 2'h3 : 2'h0;
    else if (wait_q != 2'h0)
      wait_q <= wait_q - 2'h1;
  end
endmodule
`default_nettype wire

// [sim/dcc_chk.sv]
// port assertions for the dma channel block
// bound into dcc_top; one clock, synchronous reset
`timescale 1ns/1ns
`default_nettype none

module dcc_chk #(
  parameter int NCH = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // pins and memory
  input wire logic nmi_i,
  input wire dcc_pkg::dcc_mem_req_t mem_o,
  input wire logic mem_ack_i,
  input wire logic [NCH-1:0] irq_o
);
  logic go;
  logic rd;
  logic ctl_rd;
  logic [3:0] nmi_q;
  assign go = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd = go && !wb_we_i && wb_adr_i < 8'h60;
  assign ctl_rd = rd && wb_adr_i[4:0] == 5'h00;
  // masks memory checks after reset or nmi
  always_ff @(posedge clk_i)
    nmi_q <= (nmi_i || rst_i) ? 4'h8 : nmi_q - 4'(nmi_q != 4'h0);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence rd_done_s;
    mem_ack_i && mem_o.req && !mem_o.we && nmi_q == 4'h0;
  endsequence
  sequence wr_go_s;
    mem_o.req && mem_o.we;
  endsequence
  ack_next_a: assert property (go |=> wb_ack_o)
    else $error("no ack");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("long ack");
  ext_zero_a: assert property (rd && wb_adr_i[3:0] == 4'h8 ||
    rd && wb_adr_i[4:0] == 5'h10 |=> wb_dat_o == 32'h0)
    else $error("ext word nonzero");
  ctl_read_a: assert property (ctl_rd |=> wb_dat_o[15:8] == 8'h00
    && !wb_dat_o[0])
    else $error("bad control read");
  iv_first_a: assert property (go && !wb_we_i &&
    wb_adr_i == 8'h60 && irq_o[0] |=> wb_dat_o == 32'h2)
    else $error("bad vector");
  irq_cause_a: assert property (ctl_rd && wb_adr_i[6:5] == 2'h0 &&
    irq_o[0] |=> wb_dat_o[3:2] == 2'h3)
    else $error("irq without cause");
  req_hold_a: assert property (mem_o.req && !mem_ack_i &&
    nmi_q == 4'h0 && !nmi_i |=> mem_o.req)
    else $error("req dropped");
  unit_a: assert property (rd_done_s |=> !mem_o.req ##1 wr_go_s)
    else $error("no write after read");
endmodule

bind dcc_top dcc_chk #(.NCH(NCH)) chk (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .nmi_i, .mem_o,
  .mem_ack_i, .irq_o);
`default_nettype wire

// [sim/dcc_top_tb.sv]
// bench for dcc_top: wishbone master, trigger and nmi pins
// dcc_mem answers the memory port; dcc_chk is bound in
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) cmp(32'(a), 32'(b))

module dcc_top_tb;
  logic clk_i = 1'b0, rst_i = 1'b1, nmi_i = 1'b0, slow = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, e, v, rng = 32'hA116E257;
  logic [2:0] trig_i = 3'h0, irq_o;
  logic wb_ack_o, mem_ack_i;
  logic [15:0] mem_rdata_i;
  dcc_pkg::dcc_mem_req_t mem_o;
  logic [31:0] rq[$], mq[$], sq[$];
  int n_mismatch = 0, checked = 0, nwr = 0;

  dcc_top dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .trig_i, .nmi_i, .mem_o,
    .mem_ack_i, .mem_rdata_i, .irq_o);
  dcc_mem mem (.clk_i, .slow_i(slow), .mem_i(mem_o), .ack_o(mem_ack_i),
    .rdata_o(mem_rdata_i));

  initial
    forever #50 clk_i = ~clk_i;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic results();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] a, input logic [31:0] b);
    checked++;
    if (a !== b)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, a, b);
    end
  endtask

  task automatic lim(input int i);
    if (i >= 400)
    begin
      n_mismatch++;
      results();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'h3;
    wb_dat_i <= d;
    i = 0;
    do
    begin
      @(posedge clk_i);
      i++;
    end
    while (wb_ack_o !== 1'b1 && i < 400);
    lim(i);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    rq.push_back(x);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic units(input int k);
    int i;
    i = 0;
    while (nwr < k && i < 400)
    begin
      @(posedge clk_i);
      i++;
    end
    lim(i);
  endtask

  // results against the oldest note
  always @(posedge clk_i)
  begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rq.size() > 0)
    begin
      e = rq.pop_front();
      `CHK(wb_dat_o, e);
    end
    if (mem_ack_i === 1'b1 && mem_o.we === 1'b0 && sq.size() > 0)
    begin
      v = sq.pop_front();
      `CHK({mem_o.byte_sel, mem_o.addr}, v);
    end
    if (mem_ack_i === 1'b1 && mem_o.we === 1'b1)
    begin
      nwr++;
      if (mq.size() > 0)
      begin
        v = mq.pop_front();
        e = {mem_o.addr[19:16], mem_o.byte_sel, mem_o.addr[10:0],
          mem_o.wdata};
        `CHK(e, v);
      end
    end
  end

  initial
  begin
    logic [7:0] b;
    logic [15:0] sa, da, x;
    int k;
    int j;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b1, 8'h7C, 32'hFFFF);
    for (int a = 0; a < 128; a += 4)
      rd(8'(a), 32'h0);
    $display("test map end");
    for (int c = 2; c >= 0; c--)
    begin
      b = 8'(c * 32);
      rng = xs(rng);
      sa = rng[15:0];
      da = rng[31:16];
      slow <= rng[0];
      x = sa ^ 16'h0A5C;
      if (c == 1)
        x = {8'h00, x[7:0]};
      bus(1'b1, b + 8'h08, 32'h5);
      bus(1'b1, b + 8'h04, 32'(sa));
      bus(1'b1, b + 8'h0C, 32'(da));
      bus(1'b1, b + 8'h10, 32'hFFF3);
      bus(1'b1, b + 8'h14, 32'h2);
      for (int u = 1; u <= 2; u++)
      begin
        sq.push_back(32'({c == 1, 4'h0, sa}));
        mq.push_back({4'h3, c == 1, da[10:0], x});
        k = nwr + 1;
        bus(1'b1, b, c == 1 ? 32'hD5 : 32'h15);
        units(k);
        rd(b + 8'h14, u == 1 ? 32'h1 : 32'h2);
        rd(b, (c == 1 ? 32'hD4 : 32'h14) | 32'(u == 2) << 3);
      end
      rd(b + 8'h04, 32'(sa));
      rd(b + 8'h0C, 32'(da));
      rd(b + 8'h10, 32'h0);
      rd(8'h60, 32'(2 * c + 2));
      `CHK(irq_o[c], 1'b1);
    end
    for (int c = 0; c < 3; c++)
    begin
      bus(1'b1, 8'(c * 32), 32'h0);
      rd(8'h60, c == 2 ? 32'h0 : 32'(2 * c + 4));
    end
    `CHK(irq_o, 3'h0);
    $display("test channel end");
    k = nwr;
    bus(1'b1, 8'h14, 32'h3);
    bus(1'b1, 8'h00, 32'h1);
    bus(1'b1, 8'h34, 32'h0);
    bus(1'b1, 8'h20, 32'h11);
    repeat (40) @(posedge clk_i);
    `CHK(nwr, k);
    for (int lv = 0; lv < 2; lv++)
    begin
      k = nwr;
      bus(1'b1, 8'h00, lv == 1 ? 32'h30 : 32'h10);
      trig_i <= 3'h7;
      repeat (40) @(posedge clk_i);
      trig_i <= 3'h0;
      repeat (40) @(posedge clk_i);
      `CHK(nwr - k == 1, lv == 0);
    end
    $display("test trigger end");
    slow <= 1'b1;
    k = nwr;
    bus(1'b1, 8'h00, 32'h11);
    for (j = 0; j < 400 && mem_o.req !== 1'b1; j++)
      @(posedge clk_i);
    lim(j);
    nmi_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    nmi_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    `CHK(nwr, k);
    rd(8'h00, 32'h12);
    $display("test abort end");
    results();
  end
endmodule
`default_nettype wire
